// [common/cop_pkg.sv]
package cop_pkg;

	// ****************************************
	// Operations
	// ****************************************
	typedef enum logic [3:0] {
		OP_ADD32 = 4'h0,
		OP_SUB32 = 4'h1,
		OP_MUL32 = 4'h2,
		OP_ADD64 = 4'h3,
		OP_SUB64 = 4'h4,
		OP_MUL64 = 4'h5,
		OP_MAC32 = 4'h6,
		OP_MSC32 = 4'h7,
		OP_MADDA = 4'h8,
		OP_MSUBA = 4'h9,
		OP_CMP32 = 4'hA,
		OP_CMP64 = 4'hB,
		OP_CMPS = 4'hC,
		OP_CMPD = 4'hD,
		OP_MOVE = 4'hE
	} op_t;

	typedef enum logic [1:0] {
		FMT_NONE = 2'h0,
		FMT_262 = 2'h1,
		FMT_163 = 2'h2,
		FMT_131 = 2'h3
	} acc_fmt_t;

	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int NUM_REGS = 16;
	localparam int NUM_ACCS = 4;
	localparam int REG_W = 64;
	localparam int ACC_W = 72;
	localparam int LAT_NORMAL = 9;
	localparam int LAT_MUL64 = 15;
	localparam int ISSUE_GAP = 2;
	localparam logic [3:0] HOST_PC_REG = 4'hF;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DBL_SIGN = 63;
	localparam int DBL_EXP_HI = 62;
	localparam int DBL_EXP_LO = 52;
	localparam int DBL_MAN_HI = 51;
	localparam int SGL_LO = 32;

	// ****************************************
	// Saturation values
	// ****************************************
	localparam logic [31:0] S32_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] S32_MIN = 32'h80000000;
	localparam logic [31:0] U32_MAX = 32'hFFFFFFFF;
	localparam logic [63:0] S64_MAX = 64'h7FFFFFFFFFFFFFFF;
	localparam logic [63:0] S64_MIN = 64'h8000000000000000;
	localparam logic [63:0] U64_MAX = 64'hFFFFFFFFFFFFFFFF;
	localparam logic [63:0] Q262_MAX = 64'h3FFFFFFFFFFFFFFF;
	localparam logic [63:0] Q262_MIN = 64'hC000000000000000;

	// ****************************************
	// Compare encodings
	// ****************************************
	localparam logic [1:0] CC_EQ = 2'h0;
	localparam logic [1:0] CC_LT = 2'h1;
	localparam logic [1:0] CC_GT = 2'h2;
	localparam logic [1:0] CC_UN = 2'h3;
	localparam logic [3:0] NZCV_EQ = 4'h4;
	localparam logic [3:0] NZCV_LT = 4'h8;
	localparam logic [3:0] NZCV_GT = 4'h9;
	localparam logic [3:0] NZCV_UN = 4'h0;

	// ****************************************
	// Accumulator mode mapping defaults
	// ****************************************
	localparam logic [1:0] MODE_262 = 2'h1;
	localparam logic [1:0] MODE_163 = 2'h2;
	localparam logic [1:0] MODE_131 = 2'h3;

endpackage : cop_pkg

// [rtl/cop_compare.sv]
`timescale 1ns/1ns
// ****************************************
// Compare unit
// ****************************************
module cop_compare (
	input wire logic [3:0] op,
	input wire logic [63:0] a,
	input wire logic [63:0] b,
	input wire logic unsigned_compare_select,
	output logic [1:0] code,
	output logic [3:0] flags
);

	// Float ordering key: flip to make signed value order monotone
	function automatic logic [63:0] fkey(input logic [63:0] v);
		fkey = v[63] ? ~v : {1'b1, v[62:0]};
	endfunction : fkey

	logic is_f;
	logic is_d;
	logic nan_a;
	logic nan_b;
	logic z_a;
	logic z_b;
	logic [63:0] ia;
	logic [63:0] ib;
	logic [63:0] ka;
	logic [63:0] kb;
	logic i_lt;
	logic f_lt;
	logic eq;
	logic lt;
	logic un;

	assign is_d = (op == 4'(cop_pkg::OP_CMPD));
	assign is_f = is_d || (op == 4'(cop_pkg::OP_CMPS));
	// Single lives in upper half, so compare upper half as a double-like key
	assign nan_a = is_d ? (&a[62:52] && |a[51:0]) : (&a[62:55] && |a[54:32]);
	assign nan_b = is_d ? (&b[62:52] && |b[51:0]) : (&b[62:55] && |b[54:32]);
	assign z_a = is_d ? ~|a[62:0] : ~|a[62:32];
	assign z_b = is_d ? ~|b[62:0] : ~|b[62:32];
	assign ka = is_d ? fkey(a) : fkey({a[63:32], 32'h00000000});
	assign kb = is_d ? fkey(b) : fkey({b[63:32], 32'h00000000});
	assign f_lt = (ka < kb) && !(z_a && z_b);
	// 32-bit compare extends from bit 31 per signedness
	assign ia = (op == 4'(cop_pkg::OP_CMP32)) ?
		{{32{a[31] & ~unsigned_compare_select}}, a[31:0]} : a;
	assign ib = (op == 4'(cop_pkg::OP_CMP32)) ?
		{{32{b[31] & ~unsigned_compare_select}}, b[31:0]} : b;
	assign i_lt = unsigned_compare_select ? (ia < ib) :
		($signed(ia) < $signed(ib));
	assign un = is_f && (nan_a || nan_b);
	assign eq = is_f ? ((ka == kb) || (z_a && z_b)) : (ia == ib);
	assign lt = is_f ? f_lt : i_lt;

	// Relation to code and flags
	always_comb begin
		if (un) begin
			code = cop_pkg::CC_UN;
			flags = cop_pkg::NZCV_UN;
		end else if (eq) begin
			code = cop_pkg::CC_EQ;
			flags = cop_pkg::NZCV_EQ;
		end else if (lt) begin
			code = cop_pkg::CC_LT;
			flags = cop_pkg::NZCV_LT;
		end else begin
			code = cop_pkg::CC_GT;
			flags = cop_pkg::NZCV_GT;
		end
	end

endmodule : cop_compare

// [rtl/cop_datapath.sv]
`timescale 1ns/1ns
// ****************************************
// Integer data path with saturation and compare
// ****************************************
module cop_datapath #(
	parameter logic [1:0] MODE_262 = cop_pkg::MODE_262,
	parameter logic [1:0] MODE_163 = cop_pkg::MODE_163,
	parameter logic [1:0] MODE_131 = cop_pkg::MODE_131
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic issue_valid,
	input wire logic [3:0] issue_op,
	input wire logic [3:0] src_a,
	input wire logic [3:0] src_b,
	input wire logic [3:0] dest,
	input wire logic [1:0] acc_sel,
	input wire logic [3:0] host_dest,
	input wire logic sync_mode,
	input wire logic unsigned_select,
	input wire logic int_saturate_disable,
	input wire logic [1:0] acc_saturation_mode,
	input wire logic load_valid,
	input wire logic [3:0] load_reg,
	input wire logic [63:0] load_data,
	input wire logic [3:0] read_reg,
	output logic issue_stall,
	output logic [63:0] read_data,
	output logic [71:0] acc_data,
	output logic [1:0] compare_code,
	output logic host_flags_valid,
	output logic [3:0] host_status_flags,
	output logic host_reg_valid,
	output logic [3:0] host_reg_index,
	output logic [31:0] host_reg_data,
	output logic result_valid
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1
	} state_t;

	// ****************************************
	// Reset release and storage
	// ****************************************
	logic rst_q1;
	logic rst_sync;
	logic [63:0] regs [cop_pkg::NUM_REGS];
	logic [71:0] accs [cop_pkg::NUM_ACCS];
	state_t state;
	logic phase;
	logic [3:0] count;
	logic [3:0] p_op;
	logic [3:0] p_dest;
	logic [1:0] p_acc;
	logic [63:0] p_res;
	logic [71:0] p_acc_res;
	logic p_us;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1 <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_sync <= rst_q1;
		end
	end

	// ****************************************
	// Operand fetch and arithmetic
	// ****************************************
	logic [63:0] a;
	logic [63:0] b;
	logic [31:0] a32;
	logic [31:0] b32;
	logic is32;
	logic is_mul;
	logic is_sub;
	logic is_cmp;
	logic is_acc;
	logic [64:0] sum;
	logic [127:0] prod_s;
	logic [127:0] prod_u;
	logic [63:0] wide;
	logic ovf;
	logic unf;
	logic [63:0] sat_res;
	logic [71:0] acc_sum;
	logic [71:0] acc_out;
	logic [1:0] cmp_code;
	logic [3:0] cmp_flags;
	logic do_issue;

	assign a = regs[src_a];
	assign b = regs[src_b];
	assign a32 = a[31:0];
	assign b32 = b[31:0];
	assign is32 = (issue_op == 4'(cop_pkg::OP_ADD32)) ||
		(issue_op == 4'(cop_pkg::OP_SUB32)) ||
		(issue_op == 4'(cop_pkg::OP_MUL32)) ||
		(issue_op == 4'(cop_pkg::OP_MAC32)) ||
		(issue_op == 4'(cop_pkg::OP_MSC32));
	assign is_mul = (issue_op == 4'(cop_pkg::OP_MUL32)) ||
		(issue_op == 4'(cop_pkg::OP_MUL64));
	assign is_sub = (issue_op == 4'(cop_pkg::OP_SUB32)) ||
		(issue_op == 4'(cop_pkg::OP_SUB64));
	assign is_cmp = (issue_op >= 4'(cop_pkg::OP_CMP32)) &&
		(issue_op <= 4'(cop_pkg::OP_CMPD));
	assign is_acc = (issue_op == 4'(cop_pkg::OP_MADDA)) ||
		(issue_op == 4'(cop_pkg::OP_MSUBA));

	// Operands taken at their width; signedness from the select bit
	assign sum = is_sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
	assign prod_s = $signed(a) * $signed(b);
	assign prod_u = a * b;

	// 32-bit MAC/MSC: d = d +/- a*b in 32-bit registers
	logic [63:0] d;
	logic [63:0] mac;
	assign d = regs[dest];
	assign mac = (issue_op == 4'(cop_pkg::OP_MSC32)) ?
		(d - (unsigned_select ? prod_u[63:0] : prod_s[63:0])) :
		(d + (unsigned_select ? prod_u[63:0] : prod_s[63:0]));

	// Exact result and range checks
	always_comb begin
		wide = 64'h0000000000000000;
		ovf = 1'b0;
		unf = 1'b0;
		if (is32) begin
			if (is_mul) begin
				wide = unsigned_select ? {32'h00000000, a32} * {32'h00000000, b32} :
					64'($signed(a32) * $signed(b32));
			end else if (issue_op == 4'(cop_pkg::OP_MAC32) ||
				issue_op == 4'(cop_pkg::OP_MSC32)) begin
				wide = mac;
			end else begin
				wide = unsigned_select ?
					(is_sub ? {32'h00000000, a32} - {32'h00000000, b32} :
					{32'h00000000, a32} + {32'h00000000, b32}) :
					(is_sub ? 64'($signed(a32)) - 64'($signed(b32)) :
					64'($signed(a32)) + 64'($signed(b32)));
			end
			if (unsigned_select) begin
				ovf = !wide[63] && |wide[62:32];
				unf = wide[63];
			end else begin
				ovf = !wide[63] && |wide[62:31];
				unf = wide[63] && !(&wide[62:31]);
			end
		end else if (is_mul) begin
			wide = unsigned_select ? prod_u[63:0] : prod_s[63:0];
			ovf = unsigned_select ? |prod_u[127:64] :
				(!prod_s[127] && (|prod_s[126:63]));
			unf = unsigned_select ? 1'b0 :
				(prod_s[127] && !(&prod_s[126:63]));
		end else begin
			wide = sum[63:0];
			if (unsigned_select) begin
				ovf = !is_sub && sum[64];
				unf = is_sub && sum[64];
			end else begin
				ovf = !a[63] && (b[63] == is_sub) && sum[63];
				unf = a[63] && (b[63] != is_sub) && !sum[63];
			end
		end
	end

	// Saturation and 32-bit sign or zero extension (per unsigned_select) on write
	always_comb begin
		sat_res = wide;
		if (is32) begin
			sat_res = {{32{wide[31] & ~unsigned_select}}, wide[31:0]};
			if (!int_saturate_disable && ovf) begin
				sat_res = unsigned_select ? {32'h00000000, cop_pkg::U32_MAX} :
					{32'h00000000, cop_pkg::S32_MAX};
			end else if (!int_saturate_disable && unf) begin
				sat_res = unsigned_select ? 64'h0000000000000000 :
					{32'hFFFFFFFF, cop_pkg::S32_MIN};
			end
		end else if (!int_saturate_disable && ovf) begin
			sat_res = unsigned_select ? cop_pkg::U64_MAX : cop_pkg::S64_MAX;
		end else if (!int_saturate_disable && unf) begin
			sat_res = unsigned_select ? 64'h0000000000000000 : cop_pkg::S64_MIN;
		end
	end

	// Accumulator update with optional format saturation
	logic [71:0] prod72;
	assign prod72 = {{8{prod_s[63]}}, prod_s[63:0]};
	assign acc_sum = (issue_op == 4'(cop_pkg::OP_MSUBA)) ?
		accs[acc_sel] - prod72 : accs[acc_sel] + prod72;

	always_comb begin
		acc_out = acc_sum;
		if (acc_saturation_mode == MODE_163) begin
			if (!acc_sum[71] && |acc_sum[70:63])
				acc_out = {8'h00, cop_pkg::S64_MAX};
			else if (acc_sum[71] && !(&acc_sum[70:63]))
				acc_out = {8'hFF, cop_pkg::S64_MIN};
		end else if (acc_saturation_mode == MODE_262) begin
			if (!acc_sum[71] && |acc_sum[70:62])
				acc_out = {8'h00, cop_pkg::Q262_MAX};
			else if (acc_sum[71] && !(&acc_sum[70:62]))
				acc_out = {8'hFF, cop_pkg::Q262_MIN};
		end else if (acc_saturation_mode == MODE_131) begin
			if (!acc_sum[71] && |acc_sum[70:63])
				acc_out = {8'h00, cop_pkg::S32_MAX, 32'h00000000};
			else if (acc_sum[71] && !(&acc_sum[70:63]))
				acc_out = {8'hFF, cop_pkg::S32_MIN, 32'h00000000};
			else
				acc_out = {acc_sum[71:32], 32'h00000000};
		end
	end

	cop_compare u_cmp (
		.op(issue_op),
		.a(a),
		.b(b),
		.unsigned_compare_select(unsigned_select),
		.code(cmp_code),
		.flags(cmp_flags)
	);

	// ****************************************
	// Issue, latency and stall control
	// ****************************************
	// One op in flight keeps dependencies trivially resolved
	assign do_issue = issue_valid && !issue_stall && phase;
	logic [3:0] next_count;
	assign next_count = (issue_op == 4'(cop_pkg::OP_MUL64)) ?
		4'(cop_pkg::LAT_MUL64) : 4'(cop_pkg::LAT_NORMAL);

	// Half-rate enable for the arithmetic path
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			phase <= 1'b0;
			state <= ST_IDLE;
			count <= 4'h0;
			issue_stall <= 1'b1;
		end else begin
			phase <= ~phase;
			unique case (state)
				ST_IDLE: begin
					issue_stall <= phase; // open on issue edge only
					if (do_issue) begin
						state <= ST_BUSY;
						count <= next_count;
						issue_stall <= 1'b1;
					end
				end
				ST_BUSY: begin
					count <= count - 4'h1;
					// Busy state takes no op, so release only toward the
					// issue phase that follows the write-back
					issue_stall <= sync_mode ? (count > 4'h1 || phase) :
						(count > 4'h2 || phase);
					if (count == 4'h1)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// Captured pending result
	always_ff @(posedge clk) begin
		if (do_issue) begin
			p_op <= issue_op;
			p_dest <= dest;
			p_acc <= acc_sel;
			p_res <= (issue_op == 4'(cop_pkg::OP_MOVE)) ? a : sat_res;
			p_acc_res <= acc_out;
			p_us <= is_cmp;
		end
	end

	// ****************************************
	// Register file write and outputs
	// ****************************************
	logic wb;
	assign wb = (state == ST_BUSY) && (count == 4'h1);

	always_ff @(posedge clk) begin
		if (wb && !p_us && p_op != 4'(cop_pkg::OP_MADDA) &&
			p_op != 4'(cop_pkg::OP_MSUBA))
			regs[p_dest] <= p_res;
		else if (load_valid)
			regs[load_reg] <= load_data;
		if (wb && (p_op == 4'(cop_pkg::OP_MADDA) || p_op == 4'(cop_pkg::OP_MSUBA)))
			accs[p_acc] <= p_acc_res;
		read_data <= regs[read_reg];
		acc_data <= accs[read_reg[1:0]];
	end

	// Compare results go to host register or host flags
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			compare_code <= 2'h0;
			host_flags_valid <= 1'b0;
			host_status_flags <= 4'h0;
			host_reg_valid <= 1'b0;
			host_reg_index <= 4'h0;
			host_reg_data <= 32'h00000000;
			result_valid <= 1'b0;
		end else begin
			result_valid <= wb;
			host_flags_valid <= 1'b0;
			host_reg_valid <= 1'b0;
			if (do_issue && is_cmp) begin
				compare_code <= cmp_code;
				host_reg_index <= host_dest;
				host_status_flags <= cmp_flags;
				host_reg_data <= {cmp_flags, 26'h0000000, cmp_code};
				host_flags_valid <= (host_dest == cop_pkg::HOST_PC_REG);
				host_reg_valid <= (host_dest != cop_pkg::HOST_PC_REG);
			end
		end
	end

endmodule : cop_datapath

// [test/coprocessor_int_sat_compare_chk.sv]
`timescale 1ns/1ns
// ********
// Port timing and encoding checks
// ********
module coprocessor_int_sat_compare_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic issue_valid,
	input wire logic [3:0] issue_op,
	input wire logic [3:0] host_dest,
	input wire logic sync_mode,
	input wire logic issue_stall,
	input wire logic host_flags_valid,
	input wire logic [3:0] host_status_flags,
	input wire logic host_reg_valid,
	input wire logic [3:0] host_reg_index,
	input wire logic [31:0] host_reg_data,
	input wire logic result_valid
);
	// Accepted request and its kind
	wire take = issue_valid && !issue_stall;
	wire cmp = issue_op >= cop_pkg::OP_CMP32 && issue_op <= cop_pkg::OP_CMPD;
	wire mul = take && issue_op == cop_pkg::OP_MUL64;
	wire alu = take && !cmp && issue_op != cop_pkg::OP_MUL64;
	wire icmp = take && cmp && issue_op <= cop_pkg::OP_CMP64;
	wire [1:0] rc = host_reg_data[1:0];
	wire [3:0] rf = host_reg_data[31:28];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	norm_lat_a: assert property (
		alu |-> ##2 !result_valid [*8] ##1 result_valid)
		else $error("ordinary result off time");
	mul_lat_a: assert property (
		mul |-> ##9 !result_valid [*7] ##1 result_valid)
		else $error("long multiply result off time");
	cmp_flags_a: assert property (
		take && cmp && host_dest == 4'hF |=> host_flags_valid && !host_reg_valid)
		else $error("flag destination not honoured");
	cmp_reg_a: assert property (
		take && cmp && host_dest != 4'hF
		|=> host_reg_valid && host_reg_index == $past(host_dest))
		else $error("register destination not honoured");
	code_pair_a: assert property (
		host_reg_valid |-> rc == 2'h0 && rf == 4'h4 || rc == 2'h1 && rf == 4'h8
		|| rc == 2'h2 && rf == 4'h9 || rc == 2'h3 && rf == 4'h0)
		else $error("code and flags do not pair");
	flag_set_a: assert property (
		host_flags_valid |-> host_status_flags inside {4'h4, 4'h8, 4'h9, 4'h0})
		else $error("illegal flag pattern");
	int_order_a: assert property (
		icmp |=> (host_reg_valid ? rc != 2'h3 : host_status_flags != 4'h0))
		else $error("unordered from integer compare");
	half_rate_a: assert property (
		!issue_stall |=> issue_stall)
		else $error("issue open two cycles running");
	busy_hold_a: assert property (
		take && !cmp |=> issue_stall [*6])
		else $error("stall dropped while op in flight");
	sync_hold_a: assert property (
		take && !cmp && sync_mode |=> issue_stall [*8])
		else $error("lock-step stall released early");
	cover property (mul);
	cover property (take && cmp && host_dest == 4'hF);
	cover property (alu && sync_mode);
endmodule : coprocessor_int_sat_compare_chk
bind cop_datapath coprocessor_int_sat_compare_chk u_chk (.clk, .rst_b,
	.issue_valid, .issue_op, .host_dest, .sync_mode, .issue_stall,
	.host_flags_valid, .host_status_flags, .host_reg_valid,
	.host_reg_index, .host_reg_data, .result_valid);

// [test/host_cond_model.sv]
`timescale 1ns/1ns
// ********
// Host side: flag capture and condition evaluation
// ********
module host_cond_model (
	input wire logic clk,
	input wire logic host_flags_valid,
	input wire logic [3:0] host_status_flags,
	input wire logic [3:0] cond,
	output logic cond_pass
);
	logic [3:0] nzcv;
	wire n = nzcv[3];
	wire z = nzcv[2];
	wire v = nzcv[0];
	// Status word takes the flags of each compare aimed at it
	always_ff @(posedge clk) begin
		if (host_flags_valid) begin
			nzcv <= host_status_flags;
		end
	end
	// Only relation codes, always and never are used
	always_comb begin
		case (cond)
		4'h0: cond_pass = z;
		4'h1: cond_pass = !z;
		4'hA: cond_pass = n == v;
		4'hB: cond_pass = n != v;
		4'hC: cond_pass = !z && n == v;
		4'hD: cond_pass = z || n != v;
		4'hE: cond_pass = 1'b1;
		default: cond_pass = 1'b0;
		endcase
	end
endmodule : host_cond_model

// [test/coprocessor_int_sat_compare_tb_top.sv]
`timescale 1ns/1ns
module coprocessor_int_sat_compare_tb_top;
	logic clk, rst_b, issue_valid, sync_mode, unsigned_select;
	logic int_saturate_disable, load_valid, issue_stall, result_valid;
	logic host_flags_valid, host_reg_valid, cond_pass;
	logic [3:0] issue_op, src_a, src_b, dest, host_dest, load_reg, read_reg;
	logic [3:0] host_status_flags, host_reg_index, cond;
	logic [1:0] compare_code;
	logic [31:0] host_reg_data;
	logic [63:0] load_data, read_data;
	int n_mismatch, compares, cycles;
	cop_datapath DUT (.clk, .rst_b, .issue_valid, .issue_op, .src_a, .src_b,
		.dest, .acc_sel(2'h0), .host_dest, .sync_mode, .unsigned_select,
		.int_saturate_disable, .acc_saturation_mode(2'h0), .load_valid,
		.load_reg, .load_data, .read_reg, .issue_stall, .read_data,
		.acc_data(), .compare_code, .host_flags_valid, .host_status_flags,
		.host_reg_valid, .host_reg_index, .host_reg_data, .result_valid);
	host_cond_model u_host (.clk, .host_flags_valid, .host_status_flags,
		.cond, .cond_pass);
	// ********
	// Checking and closing
	// ********
	task automatic conclude();
		if (n_mismatch == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [63:0] e,
		input logic [63:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic check_lat(input int e, input int g);
		compares++;
		if (g != e) begin
			n_mismatch++;
			$display("[FAIL] latency expected %0d seen %0d", e, g);
		end
	endtask : check_lat
	// ********
	// Port drivers
	// ********
	task automatic load(input logic [3:0] r, input logic [63:0] d);
		@(posedge clk);
		load_valid <= 1'b1;
		load_reg <= r;
		load_data <= d;
		@(posedge clk);
		load_valid <= 1'b0;
	endtask : load
	// Holds the request until taken, then counts cycles to the answer
	task automatic issue(input logic [3:0] op, input logic [3:0] hd,
		output int lat);
		int n;
		n = 0;
		@(posedge clk);
		issue_valid <= 1'b1;
		issue_op <= op;
		host_dest <= hd;
		@(negedge clk);
		while (issue_stall !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		issue_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (result_valid !== 1'b1 && host_flags_valid !== 1'b1
			&& host_reg_valid !== 1'b1 && lat < 40);
	endtask : issue
	task automatic alu(input logic [3:0] op, input logic [1:0] cfg,
		input logic [63:0] a, input logic [63:0] b, input logic [63:0] e);
		int lat;
		@(posedge clk);
		unsigned_select <= cfg[1];
		int_saturate_disable <= cfg[0];
		load(4'h1, a);
		load(4'h2, b);
		issue(op, 4'h0, lat);
		check_lat(op == cop_pkg::OP_MUL64 ? 16 : 10, lat);
		@(posedge clk);
		read_reg <= 4'h3;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("register result", e, read_data);
	endtask : alu
	task automatic cmp(input logic [3:0] op, input logic [1:0] cfg,
		input logic [63:0] a, input logic [63:0] b, input logic [3:0] hd,
		input logic [1:0] c);
		int lat;
		logic [3:0] f;
		f = c == 2'h0 ? 4'h4 : c == 2'h1 ? 4'h8 : c == 2'h2 ? 4'h9 : 4'h0;
		@(posedge clk);
		unsigned_select <= cfg[1];
		load(4'h1, a);
		load(4'h2, b);
		issue(op, hd, lat);
		check_lat(1, lat);
		if (hd == 4'hF) begin
			check("host flags", 64'(f), 64'(host_status_flags));
		end else begin
			check("host index", 64'(hd), 64'(host_reg_index));
			check("host data", 64'({f, 26'h0, c}), 64'(host_reg_data));
		end
		@(negedge clk);
		check("compare code", 64'(c), 64'(compare_code));
		for (int i = 0; i < 3 && hd == 4'hF; i++) begin
			@(posedge clk);
			cond <= i == 0 ? 4'h0 : i == 1 ? 4'hB : 4'hC;
			@(negedge clk);
			check("host condition", 64'(c == i), 64'(cond_pass));
		end
	endtask : cmp
	// ********
	// Scenarios
	// ********
	task automatic sat32();
		@(posedge clk);
		sync_mode <= 1'b0;
		alu(cop_pkg::OP_ADD32, 2'h0, 64'h7FFFFFFF, 64'h1,
			64'h7FFFFFFF);
		alu(cop_pkg::OP_SUB32, 2'h0, 64'hFFFFFFFF80000000, 64'h1,
			64'hFFFFFFFF80000000);
		alu(cop_pkg::OP_MUL32, 2'h0, 64'h10000, 64'h10000,
			64'h7FFFFFFF);
		alu(cop_pkg::OP_ADD32, 2'h1, 64'h7FFFFFFF, 64'h1,
			64'hFFFFFFFF80000000);
		alu(cop_pkg::OP_ADD32, 2'h2, 64'hFFFFFFFF, 64'h1,
			64'hFFFFFFFF);
		alu(cop_pkg::OP_SUB32, 2'h2, 64'h0, 64'h1, 64'h0);
		alu(cop_pkg::OP_SUB32, 2'h3, 64'h0, 64'h1,
			64'hFFFFFFFF);
	endtask : sat32
	task automatic sat64();
		@(posedge clk);
		sync_mode <= 1'b1;
		alu(cop_pkg::OP_ADD64, 2'h0, cop_pkg::S64_MAX, 64'h1,
			cop_pkg::S64_MAX);
		alu(cop_pkg::OP_SUB64, 2'h0, cop_pkg::S64_MIN, 64'h1,
			cop_pkg::S64_MIN);
		alu(cop_pkg::OP_ADD64, 2'h2, cop_pkg::U64_MAX, 64'h1,
			cop_pkg::U64_MAX);
		alu(cop_pkg::OP_ADD64, 2'h1, cop_pkg::S64_MAX, 64'h1,
			cop_pkg::S64_MIN);
		alu(cop_pkg::OP_MUL64, 2'h0, 64'h100000000, 64'h100000000,
			cop_pkg::S64_MAX);
		alu(cop_pkg::OP_MUL64, 2'h0, 64'h3, 64'h5, 64'hF);
	endtask : sat64
	task automatic compare();
		@(posedge clk);
		sync_mode <= 1'b0;
		cmp(cop_pkg::OP_CMP32, 2'h0, '1, 64'h1, 4'hF, 2'h1);
		cmp(cop_pkg::OP_CMP32, 2'h2, '1, 64'h1, 4'hF, 2'h2);
		cmp(cop_pkg::OP_CMP32, 2'h0, 64'h100000005, 64'h5, 4'hF,
			2'h0);
		cmp(cop_pkg::OP_CMP64, 2'h2, cop_pkg::S64_MIN, 64'h1, 4'h3,
			2'h2);
		cmp(cop_pkg::OP_CMP64, 2'h0, cop_pkg::S64_MIN, 64'h1, 4'h6,
			2'h1);
		cmp(cop_pkg::OP_CMPD, 2'h2, 64'h3FF0000000000000,
			64'h4000000000000000, 4'hF, 2'h1);
		cmp(cop_pkg::OP_CMPD, 2'h0, 64'h7FF8000000000000,
			64'h3FF0000000000000, 4'h4, 2'h3);
		cmp(cop_pkg::OP_CMPS, 2'h0, 64'h4000000000000000,
			64'h3F800000FFFFFFFF, 4'hF, 2'h2);
	endtask : compare
	// ********
	// Clock, watchdog and main sequence
	// ********
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		{rst_b, issue_valid, load_valid, sync_mode} = 4'h0;
		{unsigned_select, int_saturate_disable} = 2'h0;
		{issue_op, dest, host_dest, load_reg, read_reg, cond} = 24'h0;
		src_a = 4'h1;
		src_b = 4'h2;
		dest = 4'h3;
		load_data = 64'h0;
		n_mismatch = 0;
		compares = 0;
		cycles = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		sat32();
		sat64();
		compare();
		conclude();
	end
endmodule : coprocessor_int_sat_compare_tb_top
